// >>> rtl/fpec_pkg.sv
// Purpose: Shared constants and types for the flash program/erase control
// Assumes: 32-bit AXI4-Lite register bus, 16-bit flash address space
// Notes: Array model is behavioural storage inside the main module
package fpec_pkg;
  // Register byte offsets on the control bus
  localparam logic [7:0] FPEC_OFS_CTRL = 8'h00; // Program/erase control
  localparam logic [7:0] FPEC_OFS_ADDR = 8'h04; // Array address window
  localparam logic [7:0] FPEC_OFS_DATA = 8'h08; // Array data window
  localparam logic [7:0] FPEC_OFS_STAT = 8'h0C; // Sequencer status
  // Control register bit positions
  localparam int FPEC_BIT_PROG = 0;  // program_select
  localparam int FPEC_BIT_ERASE = 1; // erase select
  localparam int FPEC_BIT_WHOLE = 2; // whole-array erase select
  localparam int FPEC_BIT_HV = 3;    // high_voltage_enable
  localparam logic [7:0] FPEC_CTRL_RST = 8'h00;
  // Array geometry
  localparam logic [15:0] FPEC_ARR_LO = 16'hDE00;     // Lowest array address
  localparam logic [15:0] FPEC_PROT_ADDR = 16'hFF7E;  // Protect byte location
  localparam logic [15:0] FPEC_VEC_LO = 16'hFFDE;     // Vector page start
  localparam logic [15:0] FPEC_TOP = 16'hFFFF;        // Array top
  localparam logic [7:0] FPEC_PROT_OPEN = 8'hFF;      // Nothing protected
  localparam logic [15:0] FPEC_PAGE_MASK = 16'hFFC0;  // 64-byte page
  localparam logic [15:0] FPEC_ROW_MASK = 16'hFFE0;   // 32-byte row
  localparam logic [7:0] FPEC_ERASED = 8'hFF;
  // Timing (ns) and cycle counts at 125 MHz
  localparam int FPEC_CLK_NS = 8;
  localparam int FPEC_SETUP_WAIT_NS = 10000;    // setup_wait_time
  localparam int FPEC_READ_RECOVERY_NS = 1000;  // read_recovery_time
  localparam int FPEC_SETUP_CYC = (FPEC_SETUP_WAIT_NS + FPEC_CLK_NS - 1) / FPEC_CLK_NS;
  localparam int FPEC_RCV_CYC = (FPEC_READ_RECOVERY_NS + FPEC_CLK_NS - 1) / FPEC_CLK_NS;
  // Sequence progress
  typedef enum logic [2:0] {
    FPEC_IDLE, FPEC_SELECTED, FPEC_PROT_READ, FPEC_ARMED, FPEC_HIGHV, FPEC_RECOVER
  } fpec_state_e;
  // Array access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] data;
  } fpec_arr_req_s;
endpackage

// >>> rtl/fpec_prot.sv
// Purpose: Decides whether a flash address lies in the protected range
// Assumes: Protect bits are the stored protect byte
// Notes: Pure combinational helper
`timescale 1ns/1ps
`default_nettype none
module fpec_prot (
  input wire logic [7:0] i_bits,
  input wire logic [15:0] i_addr,
  input wire logic i_bypass,
  output logic o_protected,
  output logic o_any
);
  import fpec_pkg::*;
  logic [15:0] start_addr; // Protect start address
  // Start address from bits at [13:6], top two set, low six clear
  assign start_addr = {2'b11, i_bits, 6'b00_0000};
  // Any value other than all ones protects something while i_bypass is low
  assign o_any = (i_bits != FPEC_PROT_OPEN) && !i_bypass;
  // Range reaches the top; all zeros start below the array
  assign o_protected = o_any && ((i_addr >= start_addr) || (i_bits <= 8'h78));
endmodule // fpec_prot
`default_nettype wire

// >>> rtl/fpec_timer.sv
// Purpose: Counts down a minimum wait in clock cycles
// Assumes: Load pulse restarts the count
// Notes: o_done is a level while count is zero
`timescale 1ns/1ps
`default_nettype none
module fpec_timer #(
  parameter int W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_load,
  input wire logic [W-1:0] i_count,
  output logic o_done
);
  logic [W-1:0] cnt_reg; // Remaining cycles
  // Load wins over counting
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= '0;
    end else if (i_load) begin
      cnt_reg <= i_count;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end
  assign o_done = (cnt_reg == '0);
endmodule // fpec_timer
`default_nettype wire

// >>> rtl/fpec_ctrl.sv
// Purpose: Flash program/erase control with AXI4-Lite registers and array model
// Assumes: Host runs the documented step sequences by register accesses
// Notes: Array accesses go through ADDR then DATA registers
// Overview of operation
// - HV set only after select and steps
// - HV bit drives charge pump output
// - Whole bit picks array versus page erase
// - Erase and program never both one
// - Page erase sets 64 aligned bytes
// - Vector page cleared only by whole erase
// - Whole erase blocked if protect not FF
// - Program stays within one 32-byte row
// - Program select latches later writes
// - Protected range start to top refused
// - All zeros protect all, ones none
// - Protect byte itself locked for bits FD or lower
// - Test high voltage bypasses protection
// - Start address from bits 13 to 6
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fpec_ctrl #(
  parameter int DEPTH = 8704
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_test_high_voltage,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_charge_pump_on
);
  import fpec_pkg::*;

  logic [7:0] mem [0:DEPTH-1]; // Flash array cells
  logic [7:0] ctrl_reg; // Program/erase control bits
  logic [15:0] addr_reg; // Address window
  logic [7:0] aw_reg; // Held write address
  logic aw_full_reg; // Write address taken
  logic [31:0] w_reg; // Held write data
  logic [3:0] ws_reg; // Held strobes
  logic w_full_reg; // Write data taken
  fpec_state_e state_reg; // Sequence progress
  logic [15:0] target_reg; // Latched erase/program target
  logic row_bad_reg; // Row crossed during programming
  logic [7:0] prot_bits_reg; // Copy of protect byte
  logic hv_refused_reg; // Last HV request was refused
  logic do_wr; // Register write this cycle
  logic arr_wr; // Array write via data window
  logic arr_rd; // Array read via data window
  logic ctrl_wr; // Control register write
  logic [7:0] wbyte; // Written low byte
  logic prot_tgt; // Target protected
  logic prot_any; // Some block protected
  logic setup_done; // Setup wait elapsed
  logic rcv_done; // Read recovery elapsed
  logic load_setup; // Restart setup wait
  logic load_rcv; // Restart recovery wait
  logic hv_ok; // HV may be raised now
  logic [13:0] idx; // Array index of address window
  fpec_arr_req_s req; // Array request bundle

  // Map a flash address to an array index
  function automatic logic [13:0] fidx(input logic [15:0] a);
    logic [15:0] d;
    d = a - FPEC_ARR_LO;
    fidx = d[13:0];
  endfunction

  // Address lies in the flash array
  function automatic logic in_arr(input logic [15:0] a);
    in_arr = (a >= FPEC_ARR_LO);
  endfunction

  assign do_wr = aw_full_reg && w_full_reg && !o_bvalid;
  assign wbyte = w_reg[7:0];
  assign ctrl_wr = do_wr && (aw_reg == FPEC_OFS_CTRL) && ws_reg[0];
  assign req.wr = do_wr && (aw_reg == FPEC_OFS_DATA) && ws_reg[0];
  assign req.rd = i_arvalid && o_arready && (i_araddr == FPEC_OFS_DATA);
  assign req.addr = addr_reg;
  assign req.data = wbyte;
  assign arr_wr = req.wr;
  assign arr_rd = req.rd;
  assign idx = fidx(addr_reg);

  // Protection check on the latched target
  fpec_prot u_prot (
    .i_bits(prot_bits_reg),
    .i_addr(target_reg),
    .i_bypass(i_test_high_voltage),
    .o_protected(prot_tgt),
    .o_any(prot_any)
  );

  // Minimum setup wait before high voltage
  fpec_timer #(.W(16)) u_setup (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_load(load_setup),
    .i_count(16'(FPEC_SETUP_CYC)),
    .o_done(setup_done)
  );

  // Read recovery after high voltage is removed
  fpec_timer #(.W(16)) u_rcv (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_load(load_rcv),
    .i_count(16'(FPEC_RCV_CYC)),
    .o_done(rcv_done)
  );

  assign load_setup = arr_wr && (state_reg == FPEC_PROT_READ);
  assign load_rcv = ctrl_wr && ctrl_reg[FPEC_BIT_HV] && !wbyte[FPEC_BIT_HV];

  // HV allowed only after select, protect read, target write and wait
  always_comb begin
    hv_ok = (state_reg == FPEC_ARMED) && setup_done;
    if (ctrl_reg[FPEC_BIT_ERASE] && ctrl_reg[FPEC_BIT_WHOLE] && prot_any) begin
      hv_ok = 1'b0; // Whole erase blocked under protection
    end
    if (prot_tgt) begin
      hv_ok = 1'b0; // Protected target refused
    end
  end

  // Write address and data channels, taken in either order
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_reg <= 8'h00;
      w_reg <= 32'h0000_0000;
      ws_reg <= 4'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_full_reg <= 1'b1;
        aw_reg <= i_awaddr;
      end else if (do_wr) begin
        aw_full_reg <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_full_reg <= 1'b1;
        w_reg <= i_wdata;
        ws_reg <= i_wstrb;
      end else if (do_wr) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  // Ready flops: accept one item per channel until the response goes out
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
    end else begin
      o_awready <= !aw_full_reg && !(i_awvalid && o_awready) && !o_bvalid;
      o_wready <= !w_full_reg && !(i_wvalid && o_wready) && !o_bvalid;
    end
  end

  // Write response, one cycle after both items are held
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_bvalid <= 1'b0;
      o_bresp <= 2'b00;
    end else if (do_wr) begin
      o_bvalid <= 1'b1;
      o_bresp <= (aw_reg > FPEC_OFS_STAT) ? 2'b10 : 2'b00; // Offsets above STAT give SLVERR
    end else if (o_bvalid && i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // Control register with interlock and HV gate
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_reg <= FPEC_CTRL_RST;
      hv_refused_reg <= 1'b0;
    end else if (ctrl_wr) begin
      // Both selects in one write: keep old selects
      if (!(wbyte[FPEC_BIT_PROG] && wbyte[FPEC_BIT_ERASE])) begin
        ctrl_reg[FPEC_BIT_PROG] <= wbyte[FPEC_BIT_PROG] && !ctrl_reg[FPEC_BIT_ERASE];
        ctrl_reg[FPEC_BIT_ERASE] <= wbyte[FPEC_BIT_ERASE] && !ctrl_reg[FPEC_BIT_PROG];
      end
      ctrl_reg[FPEC_BIT_WHOLE] <= wbyte[FPEC_BIT_WHOLE];
      if (wbyte[FPEC_BIT_HV] && !ctrl_reg[FPEC_BIT_HV]) begin
        ctrl_reg[FPEC_BIT_HV] <= hv_ok; // Refused rise leaves it clear
        hv_refused_reg <= !hv_ok;
      end else begin
        ctrl_reg[FPEC_BIT_HV] <= wbyte[FPEC_BIT_HV] && ctrl_reg[FPEC_BIT_HV];
      end
    end
  end

  // Charge pump follows the HV bit
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_charge_pump_on <= 1'b0;
    end else begin
      o_charge_pump_on <= ctrl_reg[FPEC_BIT_HV];
    end
  end

  // Address window register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      addr_reg <= 16'h0000;
    end else if (do_wr && aw_reg == FPEC_OFS_ADDR) begin
      addr_reg <= w_reg[15:0];
    end
  end

  // Step tracking of the host sequence
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= FPEC_IDLE;
      target_reg <= 16'h0000;
      row_bad_reg <= 1'b0;
    end else begin
      case (state_reg)
        FPEC_IDLE: begin
          if (ctrl_reg[FPEC_BIT_PROG] || ctrl_reg[FPEC_BIT_ERASE]) begin
            state_reg <= FPEC_SELECTED;
          end
        end
        FPEC_SELECTED: begin
          // Protect byte must be read after select
          if (arr_rd && addr_reg == FPEC_PROT_ADDR) begin
            state_reg <= FPEC_PROT_READ;
          end
        end
        FPEC_PROT_READ: begin
          if (arr_wr) begin
            target_reg <= addr_reg; // Latch target
            row_bad_reg <= 1'b0;
            state_reg <= FPEC_ARMED;
          end
        end
        FPEC_ARMED: begin
          if (ctrl_reg[FPEC_BIT_HV]) begin
            state_reg <= FPEC_HIGHV;
          end
        end
        FPEC_HIGHV: begin
          // Programming write outside the latched row fails the cycle
          if (arr_wr && ctrl_reg[FPEC_BIT_PROG] &&
              ((addr_reg & FPEC_ROW_MASK) != (target_reg & FPEC_ROW_MASK))) begin
            row_bad_reg <= 1'b1;
          end
          if (!ctrl_reg[FPEC_BIT_HV]) begin
            state_reg <= FPEC_RECOVER;
          end
        end
        FPEC_RECOVER: begin
          if (rcv_done && !load_rcv) begin
            state_reg <= FPEC_IDLE;
          end
        end
        default: begin
          state_reg <= FPEC_IDLE;
        end
      endcase
      // Dropping selects before HV abandons the sequence
      if (!ctrl_reg[FPEC_BIT_PROG] && !ctrl_reg[FPEC_BIT_ERASE] &&
          (state_reg == FPEC_SELECTED || state_reg == FPEC_PROT_READ ||
           state_reg == FPEC_ARMED)) begin
        state_reg <= FPEC_IDLE;
      end
    end
  end

  // Array updates: erase when erase select drops under HV, program per byte
  always_ff @(posedge i_clk) begin
    if (state_reg == FPEC_HIGHV && ctrl_wr && ctrl_reg[FPEC_BIT_ERASE] &&
        !wbyte[FPEC_BIT_ERASE]) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (ctrl_reg[FPEC_BIT_WHOLE]) begin
          mem[i] <= FPEC_ERASED; // Whole array incl. vectors
        end else if ((16'(i) + FPEC_ARR_LO & FPEC_PAGE_MASK) ==
                     (target_reg & FPEC_PAGE_MASK) &&
                     (16'(i) + FPEC_ARR_LO) < FPEC_VEC_LO &&
                     (target_reg & FPEC_PAGE_MASK) < (FPEC_VEC_LO & FPEC_PAGE_MASK)) begin
          mem[i] <= FPEC_ERASED; // One 64-byte page, vector page kept
        end
      end
    end else if (state_reg == FPEC_HIGHV && arr_wr && ctrl_reg[FPEC_BIT_PROG] &&
                 in_arr(addr_reg) && !row_bad_reg &&
                 ((addr_reg & FPEC_ROW_MASK) == (target_reg & FPEC_ROW_MASK))) begin
      mem[idx] <= mem[idx] & wbyte; // Programming only clears bits
    end
  end

  // Protect byte copy tracks its array cell
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prot_bits_reg <= FPEC_PROT_OPEN;
    end else begin
      prot_bits_reg <= mem[fidx(FPEC_PROT_ADDR)];
    end
  end

  // Read channel; array data invalid during HV and recovery
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= 2'b00;
    end else if (o_rvalid) begin
      if (i_rready) begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rresp <= 2'b00;
      case (i_araddr)
        FPEC_OFS_CTRL: o_rdata <= {24'h00_0000, ctrl_reg};
        FPEC_OFS_ADDR: o_rdata <= {16'h0000, addr_reg};
        FPEC_OFS_DATA: begin
          if (state_reg == FPEC_HIGHV || state_reg == FPEC_RECOVER ||
              !in_arr(addr_reg)) begin
            o_rdata <= 32'h0000_0000;
            o_rresp <= 2'b10;
          end else begin
            o_rdata <= {24'h00_0000, mem[idx]};
          end
        end
        FPEC_OFS_STAT: o_rdata <= {18'h0_0000, row_bad_reg, hv_refused_reg,
                                   prot_bits_reg, 1'b0, state_reg[2:0]};
        default: begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= 2'b10;
        end
      endcase
    end else begin
      o_arready <= 1'b1;
    end
  end
endmodule // fpec_ctrl
`default_nettype wire

// >>> verif/fpec_ctrl_props.sv
// Purpose: Port-level checks of the flash program/erase control
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound onto fpec_ctrl at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module fpec_ctrl_props
  import fpec_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic o_charge_pump_on
);
  // All checks share the bus clock and sleep through reset
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // Pump moves only just after a control write is answered
  property p_pump_cause;
    $changed(o_charge_pump_on) |-> o_bvalid || $past(o_bvalid) || $past(o_bvalid, 2);
  endproperty
  a_pump_cause: assert property (p_pump_cause) else $error("pump moved with no write");
  // Array data is never handed out while the pump runs
  property p_hv_read;
    i_arvalid && o_arready && i_araddr == FPEC_OFS_DATA && o_charge_pump_on
      |=> o_rresp == 2'b10 && o_rdata == 32'h0000_0000;
  endproperty
  a_hv_read: assert property (p_hv_read) else $error("array read served under HV");
  // Unmapped offsets answer with an error and zero data
  property p_unmapped;
    i_arvalid && o_arready && i_araddr > FPEC_OFS_STAT |=> o_rresp == 2'b10 && o_rdata == 0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  // Responses stand until the master takes them
  property p_b_hold;
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");
  // Read answer one edge after the address is taken
  property p_r_lat;
    i_arvalid && o_arready |=> o_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  // Write answer two edges after both items are taken
  property p_b_lat;
    i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  // No new write is taken while one is unanswered
  property p_b_block;
    o_bvalid |-> !o_awready && !o_wready;
  endproperty
  a_b_block: assert property (p_b_block) else $error("write taken while busy");
  c_pump: cover property ($rose(o_charge_pump_on));
  c_err: cover property (o_rvalid && o_rresp == 2'b10);
  c_slow: cover property (o_bvalid && !i_bready);
endmodule // fpec_ctrl_props
bind fpec_ctrl fpec_ctrl_props i_fpec_ctrl_props (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_awvalid(i_awvalid), .o_awready(o_awready),
  .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
  .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
  .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
  .o_charge_pump_on(o_charge_pump_on)
);
`default_nettype wire

// >>> verif/fpec_host.sv
// Purpose: Host core model issuing AXI4-Lite register accesses
// Assumes: One write and one read at a time
// Notes: Slow mode delays the response ready to stress holding
`timescale 1ns/1ps
`default_nettype none
module fpec_host (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic i_awready,
  input wire logic i_wready,
  input wire logic i_bvalid,
  input wire logic i_arready,
  input wire logic i_rvalid,
  output logic [7:0] o_awaddr,
  output logic o_awvalid,
  output logic [31:0] o_wdata,
  output logic [3:0] o_wstrb,
  output logic o_wvalid,
  output logic o_bready,
  output logic [7:0] o_araddr,
  output logic o_arvalid,
  output logic o_rready,
  output logic o_hang
);
  // Idle bus at time zero
  initial begin
    {o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid, o_bready} = '0;
    {o_araddr, o_arvalid, o_rready, o_hang} = '0;
  end
  // One write; released lines show the inverse of their value
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic done;
    @(posedge i_clk);
    o_awaddr <= a;
    o_wdata <= d;
    o_wstrb <= 4'hF;
    o_awvalid <= 1'b1;
    o_wvalid <= 1'b1;
    o_bready <= !i_slow;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
      done = i_bvalid && o_bready;
      if (o_awvalid && i_awready) begin
        o_awvalid <= 1'b0;
        o_awaddr <= ~a;
      end
      if (o_wvalid && i_wready) begin
        o_wvalid <= 1'b0;
        o_wdata <= ~d;
      end
      if (!done && n >= 3) o_bready <= 1'b1;
    end while (!done && n < 400);
    o_bready <= 1'b0;
    if (!done) o_hang <= 1'b1;
  endtask
  // One read; the bench checks the answer
  task automatic rd(input logic [7:0] a);
    int n;
    logic done;
    @(posedge i_clk);
    o_araddr <= a;
    o_arvalid <= 1'b1;
    o_rready <= !i_slow;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
      done = i_rvalid && o_rready;
      if (o_arvalid && i_arready) begin
        o_arvalid <= 1'b0;
        o_araddr <= ~a;
      end
      if (!done && n >= 3) o_rready <= 1'b1;
    end while (!done && n < 400);
    o_rready <= 1'b0;
    if (!done) o_hang <= 1'b1;
  endtask
endmodule // fpec_host
`default_nettype wire

// >>> verif/testbench.sv
// Purpose: Self-checking bench for the flash program/erase control
// Assumes: Waits the design does not time are shortened
// Notes: Expected answers queue; a monitor compares in order
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fpec_pkg::*;
  localparam logic [1:0] RSP_OK = 2'b00;
  localparam logic [1:0] RSP_ERR = 2'b10;
  typedef struct packed {logic [1:0] resp; logic [31:0] data; logic [31:0] mask;} fpec_exp_s;
  logic i_clk, i_rst_b, test_hv, slow, hang;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rnd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic pump;
  logic [7:0] d1, d2, d3;
  fpec_exp_s exp_r;
  fpec_exp_s rq[$];
  logic [1:0] bq[$];
  int err_total, cmp_count, seed;
  fpec_ctrl i_fpec_ctrl (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_test_high_voltage(test_hv),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .o_charge_pump_on(pump));
  fpec_host i_fpec_host (.i_clk(i_clk), .i_slow(slow), .i_awready(awready), .i_wready(wready),
    .i_bvalid(bvalid), .i_arready(arready), .i_rvalid(rvalid), .o_awaddr(awaddr),
    .o_awvalid(awvalid), .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid),
    .o_bready(bready), .o_araddr(araddr), .o_arvalid(arvalid), .o_rready(rready),
    .o_hang(hang));
  // Bus clock, 8 ns period
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // Verdict and end of run
  task automatic finish_test;
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Monitor: each answer against the oldest note
  always @(posedge i_clk) begin
    if (rvalid && rready) begin
      exp_r = rq.pop_front();
      cmp_count++;
      if ({rresp, rdata & exp_r.mask} !== {exp_r.resp, exp_r.data & exp_r.mask}) begin
        $display("mismatch at %0t: read %h resp %b, wanted %h", $time, rdata, rresp, exp_r.data);
        err_total++;
      end
    end
    if (bvalid && bready) begin
      cmp_count++;
      if (bresp !== bq.pop_front()) begin
        $display("mismatch at %0t: write resp %b", $time, bresp);
        err_total++;
      end
    end
    // A stuck handshake ends the run
    if (hang) begin
      $display("mismatch at %0t: bus wait ran out", $time);
      err_total++;
      finish_test();
    end
  end
  task automatic waitc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                        input logic [1:0] r = RSP_OK);
    rq.push_back({r, d, m});
    i_fpec_host.rd(a);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RSP_OK);
    bq.push_back(r);
    i_fpec_host.wr(a, d);
  endtask
  // Read one array byte through the address window
  task automatic peek(input logic [15:0] fa, input logic [7:0] fd);
    reg_wr(FPEC_OFS_ADDR, 32'(fa));
    rd_chk(FPEC_OFS_DATA, 32'(fd), 32'hFF);
  endtask
  // Select, protect read, dummy write, setup wait, then try high voltage
  task automatic arm(input logic [3:0] sel, input logic [15:0] tgt, input logic ok);
    reg_wr(FPEC_OFS_CTRL, 32'(sel));
    reg_wr(FPEC_OFS_ADDR, 32'(FPEC_PROT_ADDR));
    rd_chk(FPEC_OFS_DATA, 32'h0, 32'h0);
    reg_wr(FPEC_OFS_ADDR, 32'(tgt));
    reg_wr(FPEC_OFS_DATA, 32'hFF);
    waitc(FPEC_SETUP_CYC + 8);
    reg_wr(FPEC_OFS_CTRL, 32'(sel | 4'h8));
    rd_chk(FPEC_OFS_CTRL, 32'(ok ? sel | 4'h8 : sel), 32'hF);
  endtask
  // Clear selects, hold, drop high voltage, wait out recovery
  task automatic finish_op(input int hold);
    reg_wr(FPEC_OFS_CTRL, 32'h8);
    waitc(hold);
    reg_wr(FPEC_OFS_CTRL, 32'h0);
    waitc(FPEC_RCV_CYC + 8);
  endtask
  // Two byte writes in one program cycle, then the row-crossed flag
  task automatic prog2(input logic [15:0] a1, input logic [7:0] b1, input logic [15:0] a2,
                       input logic [7:0] b2);
    logic crossed;
    crossed = (a1 & FPEC_ROW_MASK) != (a2 & FPEC_ROW_MASK);
    arm(4'h1, a1, 1'b1);
    waitc(640);
    reg_wr(FPEC_OFS_ADDR, 32'(a1));
    reg_wr(FPEC_OFS_DATA, 32'(b1));
    waitc(3760);
    reg_wr(FPEC_OFS_ADDR, 32'(a2));
    reg_wr(FPEC_OFS_DATA, 32'(b2));
    waitc(3760);
    rd_chk(FPEC_OFS_STAT, 32'(crossed) << 13, 32'h2000);
    finish_op(640);
  endtask
  // Main sequence
  initial begin
    seed = 32'h433b5d73;
    err_total = 0;
    cmp_count = 0;
    i_rst_b = 1'b0;
    test_hv = 1'b0;
    slow = 1'b0;
    repeat (12) @(posedge i_clk);
    i_rst_b <= 1'b1;
    waitc(2);
    rd_chk(FPEC_OFS_CTRL, 32'(FPEC_CTRL_RST), 32'hFFFF_FFFF);
    rd_chk(8'h10, 32'h0, 32'hFFFF_FFFF, RSP_ERR);
    reg_wr(8'h14, 32'h1, RSP_ERR);
    slow <= 1'b1;
    reg_wr(FPEC_OFS_CTRL, 32'h8);
    rd_chk(FPEC_OFS_CTRL, 32'h0, 32'hF);
    reg_wr(FPEC_OFS_CTRL, 32'h3);
    rd_chk(FPEC_OFS_CTRL, 32'h0, 32'hF);
    reg_wr(FPEC_OFS_CTRL, 32'h1);
    reg_wr(FPEC_OFS_CTRL, 32'h3);
    rd_chk(FPEC_OFS_CTRL, 32'h1, 32'hF);
    reg_wr(FPEC_OFS_CTRL, 32'h0);
    $display("test control bits done");
    // Whole erase under test voltage: the protect byte is unknown at power-up
    test_hv <= 1'b1;
    arm(4'h6, FPEC_PROT_ADDR, 1'b1);
    rd_chk(FPEC_OFS_DATA, 32'h0, 32'hFFFF_FFFF, RSP_ERR);
    finish_op(12510);
    test_hv <= 1'b0;
    peek(FPEC_ARR_LO, FPEC_ERASED);
    peek(FPEC_VEC_LO, FPEC_ERASED);
    peek(FPEC_PROT_ADDR, FPEC_ERASED);
    $display("test whole erase done");
    // Program across a row, then erase the neighbour page only
    rnd = $random(seed);
    d1 = rnd[7:0] & 8'h7F;
    d2 = rnd[15:8] & 8'h7F;
    d3 = rnd[23:16] & 8'h7F;
    prog2(16'hDE20, d1, 16'hDE3F, d2);
    prog2(16'hDE5F, d3, 16'hDE60, 8'h00);
    peek(16'hDE20, d1);
    peek(16'hDE3F, d2);
    arm(4'h2, 16'hDE40, 1'b1);
    finish_op(640);
    peek(16'hDE3F, d2);
    peek(16'hDE5F, FPEC_ERASED);
    peek(16'hDE60, FPEC_ERASED);
    $display("test program and page erase done");
    // Protect from 0xFF40 upward
    prog2(FPEC_PROT_ADDR, 8'hFD, FPEC_PROT_ADDR, 8'hFD);
    arm(4'h1, 16'hFF40, 1'b0);
    reg_wr(FPEC_OFS_CTRL, 32'h0);
    arm(4'h1, FPEC_PROT_ADDR, 1'b0);
    reg_wr(FPEC_OFS_CTRL, 32'h0);
    arm(4'h6, FPEC_ARR_LO, 1'b0);
    reg_wr(FPEC_OFS_CTRL, 32'h0);
    arm(4'h1, 16'hFF3F, 1'b1);
    finish_op(640);
    test_hv <= 1'b1;
    prog2(FPEC_PROT_ADDR, 8'h00, FPEC_PROT_ADDR, 8'h00);
    test_hv <= 1'b0;
    arm(4'h1, FPEC_ARR_LO, 1'b0);
    reg_wr(FPEC_OFS_CTRL, 32'h0);
    $display("test protection done");
    waitc(4);
    finish_test();
  end
endmodule // testbench
`default_nettype wire
